// *** rtl/e1ci_pkg.sv ***
// package: constants, types and register map of the e1 crc-4 interworking block
package e1ci_pkg;
    // frame period and alignment times
    localparam int unsigned FRAME_NS     = 125000;
    localparam int unsigned IW_TIME_MS   = 400;
    localparam int unsigned MF_TIME_MS   = 8;
    localparam int unsigned LONG_TIME_MS = 100;
    localparam int unsigned IW_FRAMES    = IW_TIME_MS * 1000000 / FRAME_NS;
    localparam int unsigned MF_FRAMES    = MF_TIME_MS * 1000000 / FRAME_NS;
    localparam int unsigned LONG_FRAMES  = LONG_TIME_MS * 1000000 / FRAME_NS;
    // register byte addresses
    localparam logic [8:0] ADR_ALGO  = 9'h000;
    localparam logic [8:0] ADR_SPARE = 9'h004;
    localparam logic [8:0] ADR_MODE  = 9'h008;
    localparam logic [8:0] ADR_CTRL  = 9'h00c;
    localparam logic [8:0] ADR_STAT  = 9'h010;
    localparam logic [1:0] PAGE_TX   = 2'h1;
    localparam logic [1:0] PAGE_RX   = 2'h2;
    // field positions
    localparam int unsigned ALGO_EN_BIT   = 0;
    localparam int unsigned ALGO_LONG_BIT = 2;
    localparam int unsigned ALGO_IW_BIT   = 3;
    localparam int unsigned ALGO_OFF_BIT  = 7;
    localparam int unsigned SPARE_RMA_BIT = 3;
    localparam int unsigned MODE_NFAS_BIT = 0;
    localparam int unsigned MODE_CCS_BIT  = 4;
    localparam int unsigned CTRL_REFR_BIT = 0;
    localparam int unsigned CTRL_NOCRC_BIT = 1;
    localparam int unsigned CTRL_RECONF_BIT = 2;
    // reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [7:0] RST_ALIGN = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SEARCH = 2'b01,
        ST_LOCK   = 2'b10,
        ST_NOCRC  = 2'b11
    } e1ci_align_state_type;

    // classic wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [8:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } e1ci_wb_req_type;

    // alignment events from the receive framer, same clock
    typedef struct packed {
        logic       frame_tick;
        logic       bfa_found;
        logic       bfa_loss;
        logic       crc_loss;
        logic       mfa_found;
        logic [7:0] bfa_offset;
        logic [7:0] mfa_offset;
    } e1ci_rx_evt_type;
endpackage

// *** rtl/e1ci_frame_timer.sv ***
// frame-counting timer with sticky expiry
`timescale 1ns/100ps
`default_nettype none
module e1ci_frame_timer #(
    parameter int unsigned LIMIT = 8
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic clear_i,
    input  wire logic run_i,
    input  wire logic tick_i,
    output logic      expired_o
);
    localparam logic [11:0] LIM = LIMIT[11:0];

    typedef struct packed {
        logic [11:0] cnt;
        logic        exp;
    } e1ci_tmr_state_type;

    e1ci_tmr_state_type q, d;

    // count frame ticks while running; clear always wins
    always_comb begin
        d = q;
        if (clear_i) begin
            d.cnt = 12'h000;
            d.exp = 1'b0;
        end else if (run_i && tick_i && !q.exp) begin
            if (q.cnt == LIM - 12'h001) begin
                d.exp = 1'b1;
            end
            d.cnt = q.cnt + 12'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired_o = q.exp;
endmodule
`default_nettype wire

// *** rtl/e1ci_ts16_tx.sv ***
// transmit time slot 16 formatter for cas and ccs
`timescale 1ns/100ps
`default_nettype none
module e1ci_ts16_tx (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             req_i,
    input  wire logic             fas_i,
    input  wire logic             ccs_i,
    input  wire logic             nfas_opt_i,
    input  wire logic [2:0]       spare_i,
    input  wire logic             rma_i,
    input  wire logic [31:0][7:0] sig_i,
    output logic      [7:0]       ts16_o,
    output logic                  vld_o
);
    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] ts16;
        logic       vld;
    } e1ci_tx_state_type;

    e1ci_tx_state_type q, d;
    logic [3:0] fr;
    logic       hold;

    // one byte per transmit frame request
    always_comb begin
        d = q;
        d.vld = 1'b0;
        fr = q.cnt[3:0];
        hold = 1'b0;
        if (req_i) begin
            d.vld = 1'b1;
            if (ccs_i) begin
                d.ts16 = sig_i[q.cnt];
                d.cnt = q.cnt + 5'h01;
            end else begin
                // pattern slips one frame until it lands on the chosen frame type
                hold = (fr == 4'h0) && (fas_i == nfas_opt_i);
                if (hold) begin
                    d.ts16 = {sig_i[15][3:0], sig_i[30][3:0]};
                end else if (fr == 4'h0) begin
                    d.ts16 = {4'h0, spare_i[0], rma_i, spare_i[1], spare_i[2]};
                end else begin
                    d.ts16 = {sig_i[fr][3:0], sig_i[5'(fr) + 5'd15][3:0]};
                end
                if (!hold) begin
                    d.cnt = {1'b0, fr + 4'h1};
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ts16_o = q.ts16;
    assign vld_o  = q.vld;
endmodule
`default_nettype wire

// *** rtl/e1ci_top.sv ***
// crc-4 interworking alignment control and slot 16 signaling
`timescale 1ns/100ps
`default_nettype none
module e1ci_top (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire e1ci_pkg::e1ci_wb_req_type wb_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    input  wire e1ci_pkg::e1ci_rx_evt_type rx_i,
    input  wire logic [7:0]               rx_ts16_i,
    input  wire logic                     rx_ts16_vld_i,
    input  wire logic [4:0]               rx_ts16_idx_i,
    input  wire logic                     tx_req_i,
    input  wire logic                     tx_fas_i,
    output logic      [7:0]               tx_ts16_o,
    output logic                          tx_ts16_vld_o,
    output logic                          no_crc4_mfa_o,
    output logic                          crc4_inhibit_o,
    output logic                          tx_e_zero_o,
    output logic                          mfa_locked_o,
    output logic                          par_search_o,
    output logic                          long_loss_o,
    output logic                          frame_restart_o,
    output logic      [7:0]               traffic_align_o
);
    typedef struct packed {
        logic [7:0]                     algo;
        logic [7:0]                     spare;
        logic [7:0]                     mode;
        logic                           nocrc;
        logic                           reframe;
        logic                           reconf;
        e1ci_pkg::e1ci_align_state_type st;
        logic [7:0]                     align;
        logic                           nomfa;
        logic                           lock;
        logic                           psearch;
        logic                           lloss;
        logic                           lprev;
        logic                           restart;
        logic [31:0]                    rdat;
        logic                           ack;
        logic [31:0][7:0]               rxsig;
        logic [31:0][7:0]               txsig;
    } e1ci_top_state_type;

    e1ci_top_state_type q, d;

    logic tclr;
    logic iw_exp;
    logic mf_exp;
    logic long_exp;
    logic bus_hit;
    logic bus_wr;

    // interworking pattern 0xxx1xx1
    function automatic logic iw_mode(input logic [7:0] a);
        iw_mode = !a[e1ci_pkg::ALGO_OFF_BIT] && a[e1ci_pkg::ALGO_IW_BIT]
                  && a[e1ci_pkg::ALGO_EN_BIT];
    endfunction

    // 100 ms pattern 0xxxx1x1, only when interworking is off
    function automatic logic long_mode(input logic [7:0] a);
        long_mode = !a[e1ci_pkg::ALGO_OFF_BIT] && a[e1ci_pkg::ALGO_LONG_BIT]
                    && a[e1ci_pkg::ALGO_EN_BIT] && !iw_mode(a);
    endfunction

    // every condition that may reset the interworking timer, apart from ST_IDLE which also holds it clear
    assign tclr = rx_i.bfa_loss
                | rx_i.crc_loss
                | q.reframe
                | q.nocrc
                | q.reconf;

    assign bus_hit = wb_i.cyc && wb_i.stb && !q.ack;
    assign bus_wr  = bus_hit && wb_i.we && wb_i.sel[0];

    // 400 ms timer runs through every parallel search
    e1ci_frame_timer #(
        .LIMIT (e1ci_pkg::IW_FRAMES)
    ) u_iw_tmr (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clear_i   (tclr || q.st == e1ci_pkg::ST_IDLE),
        .run_i     (q.st == e1ci_pkg::ST_SEARCH),
        .tick_i    (rx_i.frame_tick),
        .expired_o (iw_exp)
    );

    // 8 ms timer restarts after each parallel search
    e1ci_frame_timer #(
        .LIMIT (e1ci_pkg::MF_FRAMES)
    ) u_mf_tmr (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clear_i   (tclr || q.psearch || q.st != e1ci_pkg::ST_SEARCH),
        .run_i     (1'b1),
        .tick_i    (rx_i.frame_tick),
        .expired_o (mf_exp)
    );

    // 100 ms timer alongside the 8 ms one
    e1ci_frame_timer #(
        .LIMIT (e1ci_pkg::LONG_FRAMES)
    ) u_long_tmr (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clear_i   (tclr || q.st != e1ci_pkg::ST_SEARCH),
        .run_i     (long_mode(q.algo)),
        .tick_i    (rx_i.frame_tick),
        .expired_o (long_exp)
    );

    // transmit slot 16 formatter
    e1ci_ts16_tx u_tx (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .req_i      (tx_req_i),
        .fas_i      (tx_fas_i),
        .ccs_i      (q.mode[e1ci_pkg::MODE_CCS_BIT]),
        .nfas_opt_i (q.mode[e1ci_pkg::MODE_NFAS_BIT]),
        .spare_i    (q.spare[2:0]),
        .rma_i      (q.spare[e1ci_pkg::SPARE_RMA_BIT]),
        .sig_i      (q.txsig),
        .ts16_o     (tx_ts16_o),
        .vld_o      (tx_ts16_vld_o)
    );

    // next state: bus slave, alignment control, receive signaling store
    always_comb begin
        d = q;
        d.reframe = 1'b0;
        d.reconf  = 1'b0;
        d.psearch = 1'b0;
        d.lloss   = 1'b0;
        d.lprev   = long_exp;
        d.restart = q.reframe || q.reconf;
        // ack one cycle after the strobe, dropped the cycle after
        d.ack  = bus_hit;
        d.rdat = 32'h0000_0000;
        if (bus_hit && !wb_i.we) begin
            case (wb_i.adr)
                e1ci_pkg::ADR_ALGO:  d.rdat = {24'h00_0000, q.algo};
                e1ci_pkg::ADR_SPARE: d.rdat = {24'h00_0000, q.spare};
                e1ci_pkg::ADR_MODE:  d.rdat = {24'h00_0000, q.mode};
                e1ci_pkg::ADR_CTRL:  d.rdat = {30'h0000_0000, q.nocrc, 1'b0};
                e1ci_pkg::ADR_STAT:  d.rdat = {26'h000_0000, q.st, q.lock, q.nomfa,
                                               q.align == 8'h00, 1'b0};
                default: begin
                    if (wb_i.adr[8:7] == e1ci_pkg::PAGE_TX) begin
                        d.rdat = {24'h00_0000, q.txsig[wb_i.adr[6:2]]};
                    end else if (wb_i.adr[8:7] == e1ci_pkg::PAGE_RX) begin
                        d.rdat = {24'h00_0000, q.rxsig[wb_i.adr[6:2]]};
                    end
                end
            endcase
        end
        if (bus_wr) begin
            case (wb_i.adr)
                e1ci_pkg::ADR_ALGO:  d.algo  = wb_i.dat[7:0];
                e1ci_pkg::ADR_SPARE: d.spare = wb_i.dat[7:0];
                e1ci_pkg::ADR_MODE:  d.mode  = wb_i.dat[7:0];
                e1ci_pkg::ADR_CTRL: begin
                    d.reframe = wb_i.dat[e1ci_pkg::CTRL_REFR_BIT];
                    d.nocrc   = wb_i.dat[e1ci_pkg::CTRL_NOCRC_BIT];
                    d.reconf  = wb_i.dat[e1ci_pkg::CTRL_RECONF_BIT];
                end
                default: begin
                    if (wb_i.adr[8:7] == e1ci_pkg::PAGE_TX) begin
                        d.txsig[wb_i.adr[6:2]] = wb_i.dat[7:0];
                    end
                end
            endcase
        end
        // ccs: received slot 16 kept verbatim
        if (q.mode[e1ci_pkg::MODE_CCS_BIT] && rx_ts16_vld_i) begin
            d.rxsig[rx_ts16_idx_i] = rx_ts16_i;
        end
        // loss is honoured whatever the multiframe search is doing
        if (tclr) begin
            d.st    = e1ci_pkg::ST_IDLE;
            d.nomfa = 1'b0;
            d.lock  = 1'b0;
        end else begin
            case (q.st)
                e1ci_pkg::ST_IDLE: begin
                    if (rx_i.bfa_found) begin
                        d.st    = e1ci_pkg::ST_SEARCH;
                        d.align = rx_i.bfa_offset;
                    end
                end
                e1ci_pkg::ST_SEARCH: begin
                    if (rx_i.mfa_found) begin
                        // offset belongs to the candidate that found it
                        d.st    = e1ci_pkg::ST_LOCK;
                        d.lock  = 1'b1;
                        d.align = rx_i.mfa_offset;
                    end else if (iw_mode(q.algo) && iw_exp) begin
                        d.st    = e1ci_pkg::ST_NOCRC;
                        d.nomfa = 1'b1;
                    end else begin
                        // parallel search; the primary alignment keeps traffic
                        d.psearch = mf_exp && !q.psearch;
                        d.lloss   = long_mode(q.algo) && long_exp && !q.lprev;
                    end
                end
                e1ci_pkg::ST_LOCK: begin
                    d.lock = 1'b1;
                end
                e1ci_pkg::ST_NOCRC: begin
                    d.nomfa = 1'b1;
                end
                default: begin
                    d.st = e1ci_pkg::ST_IDLE;
                end
            endcase
        end
        // reconfiguration also drops the learned alignment
        if (q.reconf) begin
            d.align = e1ci_pkg::RST_ALIGN;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q       <= '0;
            q.algo  <= e1ci_pkg::RST_REG8;
            q.spare <= e1ci_pkg::RST_REG8;
            q.mode  <= e1ci_pkg::RST_REG8;
            q.align <= e1ci_pkg::RST_ALIGN;
            q.st    <= e1ci_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // every output straight from the state flops
    assign wb_dat_o        = q.rdat;
    assign wb_ack_o        = q.ack;
    assign no_crc4_mfa_o   = q.nomfa;
    assign crc4_inhibit_o  = q.nomfa;
    assign tx_e_zero_o     = q.nomfa;
    assign mfa_locked_o    = q.lock;
    assign par_search_o    = q.psearch;
    assign long_loss_o     = q.lloss;
    assign frame_restart_o = q.restart;
    assign traffic_align_o = q.align;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ctrl_bit(int b);
        bus_wr && wb_i.adr == e1ci_pkg::ADR_CTRL && wb_i.dat[b];
    endsequence

    sequence s_search_clean;
        q.st == e1ci_pkg::ST_SEARCH && !tclr && !rx_i.mfa_found;
    endsequence

    a_iw_expire_flag: assert property (
        s_search_clean ##0 (iw_mode(q.algo) && iw_exp) |=> no_crc4_mfa_o && tx_e_zero_o)
        else $error("interworking expiry did not flag missing crc-4");

    a_nocrc_holds: assert property (
        q.st == e1ci_pkg::ST_NOCRC && !tclr |=> tx_e_zero_o [*1] ##0 crc4_inhibit_o)
        else $error("e bits zero state left without a reset condition");

    a_start_search: assert property (
        q.st == e1ci_pkg::ST_IDLE && rx_i.bfa_found && !tclr
        |=> q.st == e1ci_pkg::ST_SEARCH && traffic_align_o == $past(rx_i.bfa_offset))
        else $error("primary alignment did not start the search");

    a_loss_resets: assert property (
        rx_i.bfa_loss |=> q.st == e1ci_pkg::ST_IDLE && !no_crc4_mfa_o && !mfa_locked_o)
        else $error("frame loss did not reset the interworking algorithm");

    a_crc_loss_reset: assert property (
        rx_i.crc_loss && !rx_i.bfa_found |=> ##1 q.st != e1ci_pkg::ST_LOCK)
        else $error("crc block loss did not reset alignment");

    a_reframe_reset: assert property (
        s_ctrl_bit(e1ci_pkg::CTRL_REFR_BIT)
        |=> ##1 q.st == e1ci_pkg::ST_IDLE && frame_restart_o)
        else $error("reframe request did not reset the timer");

    a_nocrc_mode: assert property (
        q.nocrc |=> q.st == e1ci_pkg::ST_IDLE && !no_crc4_mfa_o)
        else $error("non crc-4 mode did not hold the timer reset");

    a_psearch_keeps: assert property (
        par_search_o |-> $past(q.st) == e1ci_pkg::ST_SEARCH ##1 !par_search_o)
        else $error("parallel search pulse malformed");

    a_mfa_adopt: assert property (
        s_search_clean ##0 rx_i.mfa_found
        |=> mfa_locked_o && traffic_align_o == $past(rx_i.mfa_offset))
        else $error("multiframe alignment not adopted");

    a_long_override: assert property (
        iw_mode(q.algo) && $stable(q.algo) |-> !long_loss_o)
        else $error("100 ms action taken in interworking mode");

    a_ccs_store: assert property (
        q.mode[e1ci_pkg::MODE_CCS_BIT] && rx_ts16_vld_i
        |=> q.rxsig[$past(rx_ts16_idx_i)] == $past(rx_ts16_i))
        else $error("received slot 16 not stored verbatim");

    a_reconf_restart: assert property (
        s_ctrl_bit(e1ci_pkg::CTRL_RECONF_BIT)
        |=> ##1 traffic_align_o == 8'h00 && q.st == e1ci_pkg::ST_IDLE
            && frame_restart_o)
        else $error("reconfiguration did not restart framing");

    a_idle_timer_clear: assert property (
        q.st == e1ci_pkg::ST_IDLE |=> !iw_exp)
        else $error("interworking timer not held clear before alignment");

    a_psearch_no_clear: assert property (
        par_search_o && !tclr |=> u_iw_tmr.q.cnt >= $past(u_iw_tmr.q.cnt))
        else $error("parallel search disturbed the interworking timer");

    a_lock_kept: assert property (
        q.st == e1ci_pkg::ST_LOCK && !tclr |=> mfa_locked_o && $stable(traffic_align_o))
        else $error("adopted alignment not kept while locked");

    a_nocrc_unlocked: assert property (
        no_crc4_mfa_o |-> !mfa_locked_o && q.st == e1ci_pkg::ST_NOCRC)
        else $error("no crc-4 flag outside its state");

    a_long_pulse: assert property (
        long_loss_o |=> !long_loss_o)
        else $error("100 ms action longer than one cycle");

    a_tx_answer: assert property (
        tx_req_i |=> tx_ts16_vld_o)
        else $error("slot 16 request not answered");

    a_ccs_tx_verbatim: assert property (
        q.mode[e1ci_pkg::MODE_CCS_BIT] && tx_req_i
        |=> tx_ts16_o == $past(q.txsig[u_tx.q.cnt]))
        else $error("ccs byte not sent verbatim");

    a_cas_frame0: assert property (
        !q.mode[e1ci_pkg::MODE_CCS_BIT] && tx_req_i && u_tx.q.cnt[3:0] == 4'h0
        && tx_fas_i != q.mode[e1ci_pkg::MODE_NFAS_BIT]
        |=> tx_ts16_o[7:4] == 4'h0 && tx_ts16_o[2] == $past(q.spare[e1ci_pkg::SPARE_RMA_BIT]))
        else $error("cas frame 0 byte malformed");

    a_restart_pulse: assert property (
        frame_restart_o |=> !frame_restart_o)
        else $error("framing restart longer than one cycle");
endmodule
`default_nettype wire

// *** verif/e1ci_remote_model.sv ***
// remote line side model: frame ticks, alignment events and slot 16 bytes
`timescale 1ns/100ps
`default_nettype none
module e1ci_remote_model (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    output var e1ci_pkg::e1ci_rx_evt_type rx_o,
    output var logic [7:0]               ts16_o,
    output var logic                     ts16_vld_o,
    output var logic [4:0]               ts16_idx_o
);
    logic       tick_q = 1'b0;
    logic [3:0] ev_q   = 4'h0;
    logic [7:0] off_q  = 8'h00;
    // one frame every second clock, line time squeezed to keep runs short
    always @(posedge clk_i) tick_q <= !rst_i && !tick_q;
    // offsets only mean something with a pulse, otherwise inverted
    assign rx_o = '{tick_q, ev_q[0], ev_q[1], ev_q[2], ev_q[3], off_q, off_q};
    initial begin
        ts16_o = 8'h00;
        ts16_vld_o = 1'b0;
        ts16_idx_o = 5'h00;
    end
    // event k: 0 found, 1 loss, 2 crc loss, 3 multiframe found
    task automatic pulse(input int k, input logic [7:0] off);
        ev_q <= 4'h1 << k;
        off_q <= off;
        @(posedge clk_i);
        ev_q <= 4'h0;
        off_q <= ~off;
        @(posedge clk_i);
    endtask
    // one received slot 16 byte, data inverted once released
    task automatic send(input logic [4:0] idx, input logic [7:0] b);
        ts16_o <= b;
        ts16_idx_o <= idx;
        ts16_vld_o <= 1'b1;
        @(posedge clk_i);
        ts16_o <= ~b;
        ts16_vld_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** verif/e1ci_top_bench.sv ***
// self-checking bench for the interworking and slot 16 block
`timescale 1ns/100ps
`default_nettype none
module e1ci_top_bench;
    logic                      clk_i = 1'b0;
    logic                      rst_i = 1'b1;
    e1ci_pkg::e1ci_wb_req_type wb    = '0;
    e1ci_pkg::e1ci_rx_evt_type rx;
    logic                      tx_req = 1'b0;
    logic                      tx_fas = 1'b0;
    int                        n_long = 0, n_ps = 0, n_rs = 0;
    logic                      ack, rvld, tvld, nocrc, inh, ez, lk, ll, ps, rs;
    logic [7:0]                rts, tts, ta;
    logic [4:0]                ridx;
    logic [31:0]               rd, rdat;
    logic [31:0]               seed = 32'h0000003b;
    logic [7:0]                txr [32];
    logic [7:0]                got [40];
    logic                      fasr [40];
    int                        err_count = 0;
    int                        n_tests = 0;
    // 125 MHz clock
    always #4 clk_i = ~clk_i;
    // pulse counters; the 100 ms action must never show while interworking is on
    always @(posedge clk_i) begin
        if (ll === 1'b1) n_long <= n_long + 1;
        if (ps === 1'b1) n_ps <= n_ps + 1;
        if (rs === 1'b1) n_rs <= n_rs + 1;
    end
    e1ci_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(rd), .wb_ack_o(ack),
        .rx_i(rx), .rx_ts16_i(rts), .rx_ts16_vld_i(rvld), .rx_ts16_idx_i(ridx),
        .tx_req_i(tx_req), .tx_fas_i(tx_fas), .tx_ts16_o(tts), .tx_ts16_vld_o(tvld),
        .no_crc4_mfa_o(nocrc), .crc4_inhibit_o(inh), .tx_e_zero_o(ez), .mfa_locked_o(lk),
        .par_search_o(ps), .long_loss_o(ll), .frame_restart_o(rs), .traffic_align_o(ta));
    e1ci_remote_model rm (.clk_i(clk_i), .rst_i(rst_i), .rx_o(rx), .ts16_o(rts),
        .ts16_vld_o(rvld), .ts16_idx_o(ridx));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic test_done();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error %0t got %h expected %h", $time, g, e);
        end
    endtask
    // one classic cycle; ack is sampled at each rising edge, no fixed latency
    task automatic wbx(input logic w, input logic [8:0] a, input logic [7:0] d);
        int i;
        wb <= '{1'b1, 1'b1, w, a, 4'hf, {24'h0, d}};
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 20);
        rdat = rd;
        wb <= '0;
        @(posedge clk_i);
        if (i >= 20) begin
            chk(0, 1);
            test_done();
        end
    endtask
    task automatic ticks(input int n);
        repeat (2 * n) @(posedge clk_i);
    endtask
    // forty slot 16 requests, fas and nfas frames alternating
    task automatic txseq();
        int i;
        for (i = 0; i < 40; i++) begin
            tx_req <= 1'b1;
            tx_fas <= !i[0];
            fasr[i] = !i[0];
            @(posedge clk_i);
            tx_req <= 1'b0;
            @(posedge clk_i);
            got[i] = tts;
            chk(tvld, 1);
        end
    endtask
    initial begin
        int i, k, f0, np;
        logic [3:0] s;
        logic [31:0] r;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({nocrc, inh, ez, lk}, 0);
        wbx(1, e1ci_pkg::ADR_ALGO, 8'h0d);
        wbx(0, e1ci_pkg::ADR_ALGO, 0);
        chk(rdat, 32'h0d);
        wbx(0, 9'h040, 0);
        chk(rdat, 0);
        // each reset condition mid-count restarts the full 400 ms
        for (k = 0; k < 5; k++) begin
            rm.pulse(1, 8'h00);
            rm.pulse(0, 8'h05);
            ticks(2000);
            chk(ta, 8'h05);
            case (k)
                0: rm.pulse(1, 8'h00);
                1: rm.pulse(2, 8'h00);
                default: wbx(1, e1ci_pkg::ADR_CTRL, 8'h01 << (k - 2));
            endcase
            if (k == 3) wbx(1, e1ci_pkg::ADR_CTRL, 0);
            repeat (4) @(posedge clk_i);
            rm.pulse(0, 8'h05);
            ticks(3190);
            chk(nocrc, 0);
            ticks(12);
            chk({nocrc, inh, ez}, 3'h7);
        end
        chk(n_ps != 0, 1);
        chk(n_rs, 2);
        rm.pulse(1, 8'h00);
        rm.pulse(0, 8'h05);
        ticks(100);
        rm.pulse(3, 8'h2a);
        @(posedge clk_i);
        chk({lk, ta}, 9'h12a);
        np = n_ps;
        ticks(3300);
        chk(nocrc, 0);
        chk(n_long, 0);
        chk(n_ps, np);
        // 100 ms mode: one consequent action pulse, no interworking state
        wbx(1, e1ci_pkg::ADR_ALGO, 8'h05);
        rm.pulse(1, 8'h00);
        rm.pulse(0, 8'h05);
        ticks(790);
        chk(n_long, 0);
        ticks(20);
        chk(n_long, 1);
        chk(nocrc, 0);
        // transmit registers tagged with their own index
        for (i = 0; i < 32; i++) begin
            r = rnd();
            txr[i] = {r[2:0], i[4:0]};
            wbx(1, 9'h080 + 9'(4 * i), txr[i]);
        end
        wbx(1, e1ci_pkg::ADR_MODE, 8'h10);
        txseq();
        f0 = got[0][4:0];
        for (i = 0; i < 40; i++) chk(got[i], txr[(f0 + i) % 32]);
        for (k = 0; k < 2; k++) begin
            r = rnd();
            s = r[3:0];
            wbx(1, e1ci_pkg::ADR_SPARE, {4'h0, s});
            wbx(1, e1ci_pkg::ADR_MODE, 8'(k));
            txseq();
            f0 = 0;
            for (i = 0; i < 25; i++) if (got[i][7:4] === 4'h0) f0 = i;
            chk(got[f0], {4'h0, s[0], s[3], s[1], s[2]});
            chk(fasr[f0], k == 0);
            for (i = 1; i < 16; i++) chk(got[f0 + i], {txr[i][3:0], txr[i + 15][3:0]});
        end
        wbx(1, e1ci_pkg::ADR_MODE, 8'h10);
        for (i = 0; i < 32; i++) begin
            r = rnd();
            got[i] = r[7:0];
            rm.send(i[4:0], got[i]);
        end
        for (i = 0; i < 32; i++) begin
            wbx(0, 9'h100 + 9'(4 * i), 0);
            chk(rdat, {24'h0, got[i]});
        end
        test_done();
    end
endmodule
`default_nettype wire
